/* sbfc_pkg.sv */
`default_nettype none
package sbfc_pkg;
  // widths and depths
  localparam int CHAN_N = 2;
  localparam int DATA_W = 16;
  localparam int RX_W = 17;
  localparam int FIFO_DEPTH = 4;

  // register pointer values
  localparam logic [2:0] REG_CH0_HI = 3'h0;
  localparam logic [2:0] REG_CH0_LO = 3'h1;
  localparam logic [2:0] REG_CH1_HI = 3'h2;
  localparam logic [2:0] REG_CH1_LO = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;
  localparam logic [2:0] REG_CH0_CTRL = 3'h5;
  localparam logic [2:0] REG_CH1_CTRL = 3'h6;
  localparam logic [2:0] REG_ENABLE = 3'h7;
  localparam logic [2:0] REG_PTR_RESET = 3'h0;

  // reset values and masks
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'h7f;
  localparam logic [1:0] ENABLE_RESET = 2'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // control field positions
  localparam int CTRL_CDIV_LSB = 0;
  localparam int CTRL_DLY_LSB = 2;
  localparam int CTRL_MS_BIT = 6;

  // status field layout: per channel {err, tx empty, tx not full, rx not empty}
  localparam int STATUS_CH_W = 4;

  // spi framing
  localparam logic [2:0] SPI_BIT_INIT = 3'h7;
  localparam logic [2:0] SPI_BIT_LAST = 3'h0;
  localparam int CMD_WRITE_BIT = 7;

  // serial frame
  localparam logic [4:0] BIT_INDEX_SHORT = 5'h0b;
  localparam logic [4:0] BIT_INDEX_LONG = 5'h13;
  localparam logic [4:0] CRC_BITS = 5'h04;
  localparam logic [4:0] BIT_INDEX_LAST = 5'h00;
  localparam logic [3:0] CRC_EXPECT = 4'h0;

  // bit timing: three sub-steps per bit, gap of 4 bit times at setting 0
  localparam logic [2:0] DIV_BASE = 3'h1;
  localparam logic [7:0] GAP_TICKS_BASE = 8'h0c;

  typedef enum logic [1:0] {
    spi_idle_state,
    spi_command_state,
    spi_burst_state
  } sbfc_spi_state_t;

  typedef enum logic [3:0] {
    frame_gap_state,
    lead_delay_state,
    lead_delay1_state,
    lead_delay2_state,
    bit_low_state,
    bit_data_state,
    bit_high_state,
    rx_push_state,
    tx_pop_state
  } sbfc_eng_state_t;
endpackage
`default_nettype wire

/* sbfc_top.sv */
// Summary of operation
// - channel_enable uses bits 1:0 as channel enables; bits 7:2 read zero.
// - disabled channel holds frame_line high and signal_line low.
// - disabling a channel flushes and zeroes its FIFOs and stops its transfer.
// - reset clears FIFOs and pointers, disables channels, idles all state machines.
// - control write aborts transfer from its first bit, lines idle, for whole write.
// - after control write, flush FIFOs and time a fresh gap with new settings.
// - spi machine steps on sck rise; idle on reset or cs high, counter 7.
// - first byte is command: top bit write/read, low three bits load pointer.
// - after command, burst of register transfers until cs high or reset.
// - burst write to control register raises abort for that channel.
// - writing a data low byte pushes the transmit FIFO.
// - accessing data low byte with receive data pending pops receive FIFO.
// - receive push happens before transmit pop at frame end.
// - engine steps on scaled bit clock; reset, abort, disable force gap state.
// - enabled channel with transmit data drops frame, waits one bit in thirds.
// - bit index loads 11 for short or 19 for long messages.
// - each bit: low third, data third, high third on signal_line.
// - bit index decrements after each bit until last crc bit.
// - after last crc bit: receive push step, transmit pop step, then gap.
// - gap counter restarts at end of last crc bit, overlapping push and pop.
// - transmit FIFO is four deep, updated on push and pop requests.
// - spi and bit clock treated as unrelated; both sampled into one domain.
// - message size 0: 16 data plus 4 crc; 1: 8 data plus 4 crc, msb first.
// - divider setting scales bit clock by 1, 2, 4 or 8.
// - gap setting gives minimum 4, 8, 16 or 32 bit times between frames.
// - register pointer increments after each data transfer, wrapping 7 to 0.
`timescale 1ns/10ps
`default_nettype none

module sbfc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [PW:0] COUNT_FULL = (PW + 1)'(DEPTH);
  localparam logic [PW:0] COUNT_ONE = (PW + 1)'(1);
  localparam logic [PW-1:0] PTR_ONE = PW'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != COUNT_FULL);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  // a push into a full fifo is simply not taken
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk_sys)
  begin
    if (rst || flush)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= '0;
      end
    end
    else if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + PTR_ONE;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + PTR_ONE;
      end
      if (push && !pop)
      begin
        count <= count + COUNT_ONE;
      end
      else if (pop && !push)
      begin
        count <= count - COUNT_ONE;
      end
    end
  end
endmodule

module sbfc_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // spi slave pins
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // bit timing clock input
  input wire logic bit_clk_in,
  // physical layer lines
  output logic [1:0] frame_line,
  output logic [1:0] signal_line,
  input wire logic [1:0] return_line
);
  localparam int RX_W_L = sbfc_pkg::RX_W;

  sbfc_pkg::sbfc_spi_state_t spi_state;
  logic sck_q;
  logic cs_n_q;
  logic bclk_q;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic bclk_rise;
  logic spi_write;
  logic [2:0] bit_cnt;
  logic [6:0] in_shift;
  logic [7:0] out_shift;
  logic [7:0] byte_val;
  logic byte_done;
  logic data_done;
  logic wr_done;
  logic abort_start;
  logic [2:0] reg_ptr;
  logic [2:0] ptr_pend;
  logic load_pend;
  logic cmd_pend;
  logic [1:0] channel_enable;
  logic [7:0] ctrl_reg [2];
  logic [7:0] tx_hi [2];
  logic [1:0] abort_hold;
  logic [1:0] abort_end;
  logic [1:0] abort_now;
  logic [RX_W_L-1:0] rx_head [2];
  logic [3:0] chan_status [2];
  logic [7:0] status_live;
  logic [7:0] snap_status;
  logic [15:0] snap_rx0;
  logic [15:0] snap_rx1;

  function automatic logic [7:0] read_sel(input logic [2:0] p, input logic [7:0] st, input logic [15:0] d0,
                                          input logic [15:0] d1, input logic [7:0] c0, input logic [7:0] c1,
                                          input logic [1:0] en);
    logic [7:0] r;
    r = sbfc_pkg::BYTE_ZERO;
    unique case (p)
      sbfc_pkg::REG_CH0_HI: r = d0[15:8];
      sbfc_pkg::REG_CH0_LO: r = d0[7:0];
      sbfc_pkg::REG_CH1_HI: r = d1[15:8];
      sbfc_pkg::REG_CH1_LO: r = d1[7:0];
      sbfc_pkg::REG_STATUS: r = st;
      sbfc_pkg::REG_CH0_CTRL: r = c0;
      sbfc_pkg::REG_CH1_CTRL: r = c1;
      sbfc_pkg::REG_ENABLE: r = {6'h00, en};
    endcase
    return r;
  endfunction

  // both clocks are sampled as plain inputs; only edges are used, so their phase never matters
  assign sck_rise = spi_sck && !sck_q;
  assign sck_fall = !spi_sck && sck_q;
  assign cs_fall = !spi_cs_n && cs_n_q;
  assign bclk_rise = bit_clk_in && !bclk_q;
  assign byte_val = {in_shift, spi_mosi};
  assign byte_done = sck_rise && (spi_state != sbfc_pkg::spi_idle_state) && (bit_cnt == sbfc_pkg::SPI_BIT_LAST);
  assign data_done = byte_done && (spi_state == sbfc_pkg::spi_burst_state);
  assign wr_done = data_done && spi_write;
  assign abort_start = sck_rise && (spi_state == sbfc_pkg::spi_burst_state) && spi_write
                       && (bit_cnt == sbfc_pkg::SPI_BIT_INIT);
  assign status_live = {chan_status[1], chan_status[0]};
  assign spi_miso = out_shift[7];
  assign spi_miso_oe = !spi_cs_n;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      bclk_q <= 1'b0;
    end
    else
    begin
      sck_q <= spi_sck;
      cs_n_q <= spi_cs_n;
      bclk_q <= bit_clk_in;
    end
  end

  // spi transfer machine
  always_ff @(posedge clk_sys)
  begin
    if (rst || spi_cs_n)
    begin
      spi_state <= sbfc_pkg::spi_idle_state;
      spi_write <= 1'b0;
      bit_cnt <= sbfc_pkg::SPI_BIT_INIT;
    end
    else if (sck_rise)
    begin
      bit_cnt <= bit_cnt - 3'h1;
      unique case (spi_state)
        sbfc_pkg::spi_idle_state:
        begin
          spi_write <= spi_mosi;
          spi_state <= sbfc_pkg::spi_command_state;
        end
        sbfc_pkg::spi_command_state:
        begin
          if (bit_cnt == sbfc_pkg::SPI_BIT_LAST)
          begin
            spi_state <= sbfc_pkg::spi_burst_state;
          end
        end
        sbfc_pkg::spi_burst_state:
        begin
          spi_state <= sbfc_pkg::spi_burst_state;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      in_shift <= '0;
    end
    else if (sck_rise)
    begin
      in_shift <= byte_val[6:0];
    end
  end

  // pointer and read path; the command byte moves the pointer on the next falling edge
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      reg_ptr <= sbfc_pkg::REG_PTR_RESET;
      ptr_pend <= sbfc_pkg::REG_PTR_RESET;
      load_pend <= 1'b0;
      cmd_pend <= 1'b0;
      out_shift <= sbfc_pkg::BYTE_ZERO;
    end
    else if (spi_cs_n)
    begin
      load_pend <= 1'b0;
      cmd_pend <= 1'b0;
    end
    else if (cs_fall)
    begin
      out_shift <= read_sel(reg_ptr, status_live, rx_head[0][15:0], rx_head[1][15:0],
                            ctrl_reg[0], ctrl_reg[1], channel_enable);
    end
    else if (byte_done)
    begin
      load_pend <= 1'b1;
      cmd_pend <= (spi_state == sbfc_pkg::spi_command_state);
      if (spi_state == sbfc_pkg::spi_command_state)
      begin
        ptr_pend <= byte_val[2:0];
      end
      else
      begin
        reg_ptr <= reg_ptr + 3'h1;
      end
    end
    else if (sck_fall && load_pend)
    begin
      load_pend <= 1'b0;
      if (cmd_pend)
      begin
        reg_ptr <= ptr_pend;
      end
      out_shift <= read_sel(cmd_pend ? ptr_pend : reg_ptr, snap_status, snap_rx0, snap_rx1,
                            ctrl_reg[0], ctrl_reg[1], channel_enable);
    end
    else if (sck_fall && (bit_cnt != sbfc_pkg::SPI_BIT_INIT))
    begin
      out_shift <= {out_shift[6:0], 1'b0};
    end
  end

  // status and receive data are frozen at chip select fall so a burst sees one coherent view
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      snap_status <= sbfc_pkg::BYTE_ZERO;
      snap_rx0 <= '0;
      snap_rx1 <= '0;
    end
    else if (cs_fall)
    begin
      snap_status <= status_live;
      snap_rx0 <= rx_head[0][15:0];
      snap_rx1 <= rx_head[1][15:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      channel_enable <= sbfc_pkg::ENABLE_RESET;
    end
    else if (wr_done && (reg_ptr == sbfc_pkg::REG_ENABLE))
    begin
      channel_enable <= byte_val[1:0];
    end
  end

  genvar c;
  generate
    for (c = 0; c < sbfc_pkg::CHAN_N; c++)
    begin : g_chan
      localparam logic [2:0] PTR_HI = (c == 1) ? sbfc_pkg::REG_CH1_HI : sbfc_pkg::REG_CH0_HI;
      localparam logic [2:0] PTR_LO = (c == 1) ? sbfc_pkg::REG_CH1_LO : sbfc_pkg::REG_CH0_LO;
      localparam logic [2:0] PTR_CTRL = (c == 1) ? sbfc_pkg::REG_CH1_CTRL : sbfc_pkg::REG_CH0_CTRL;
      sbfc_pkg::sbfc_eng_state_t eng_state;
      logic chan_on;
      logic kill;
      logic flush;
      logic [1:0] bit_clock_divider;
      logic [1:0] frame_gap_setting;
      logic message_size_sel;
      logic [2:0] div_cnt;
      logic [2:0] div_max;
      logic tick;
      logic [7:0] gap_cnt;
      logic gap_done;
      logic [4:0] bit_index;
      logic [19:0] rx_shift;
      logic last_bit_end;
      logic tx_push;
      logic tx_ready;
      logic tx_valid;
      logic [15:0] tx_word;
      logic tx_pop;
      logic rx_push;
      logic rx_ready;
      logic rx_valid;
      logic rx_pop;
      logic [16:0] rx_word;
      logic [16:0] rx_word_out;
      logic tx_bit;
      logic frame_q;
      logic signal_q;

      assign chan_on = channel_enable[c];
      assign bit_clock_divider = ctrl_reg[c][sbfc_pkg::CTRL_CDIV_LSB +: 2];
      assign frame_gap_setting = ctrl_reg[c][sbfc_pkg::CTRL_DLY_LSB +: 2];
      assign message_size_sel = ctrl_reg[c][sbfc_pkg::CTRL_MS_BIT];
      assign abort_now[c] = abort_hold[c] || (abort_start && (reg_ptr == PTR_CTRL));
      assign kill = !chan_on || abort_now[c] || abort_end[c];
      assign flush = !chan_on || abort_end[c];
      assign div_max = 3'((sbfc_pkg::DIV_BASE << bit_clock_divider) - sbfc_pkg::DIV_BASE);
      assign tick = bclk_rise && (div_cnt == div_max);
      assign gap_done = gap_cnt >= 8'(sbfc_pkg::GAP_TICKS_BASE << frame_gap_setting);
      assign last_bit_end = tick && (eng_state == sbfc_pkg::bit_high_state) && (bit_index == sbfc_pkg::BIT_INDEX_LAST);
      assign tx_push = wr_done && (reg_ptr == PTR_LO);
      assign rx_pop = data_done && (reg_ptr == PTR_LO);
      assign rx_push = tick && (eng_state == sbfc_pkg::rx_push_state) && rx_ready;
      assign tx_pop = tick && (eng_state == sbfc_pkg::tx_pop_state);
      // crc is not generated here; the crc slot carries the expected constant
      assign tx_bit = (bit_index >= sbfc_pkg::CRC_BITS) ? tx_word[4'(bit_index - sbfc_pkg::CRC_BITS)] : 1'b0;
      assign rx_word[16] = (rx_shift[3:0] != sbfc_pkg::CRC_EXPECT);
      assign rx_word[15:0] = message_size_sel ? {8'h00, rx_shift[11:4]} : rx_shift[19:4];
      assign rx_head[c] = rx_valid ? rx_word_out : '0;
      assign chan_status[c] = {rx_head[c][16], !tx_valid, tx_ready, rx_valid};
      assign frame_line[c] = frame_q;
      assign signal_line[c] = signal_q;

      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          ctrl_reg[c] <= sbfc_pkg::CTRL_RESET;
          tx_hi[c] <= sbfc_pkg::BYTE_ZERO;
        end
        else if (wr_done && (reg_ptr == PTR_CTRL))
        begin
          ctrl_reg[c] <= byte_val & sbfc_pkg::CTRL_MASK;
        end
        else if (wr_done && (reg_ptr == PTR_HI))
        begin
          tx_hi[c] <= byte_val;
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (rst || spi_cs_n || data_done)
        begin
          abort_hold[c] <= 1'b0;
        end
        else if (abort_start && (reg_ptr == PTR_CTRL))
        begin
          abort_hold[c] <= 1'b1;
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          abort_end[c] <= 1'b0;
        end
        else
        begin
          abort_end[c] <= wr_done && (reg_ptr == PTR_CTRL);
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (rst || kill)
        begin
          div_cnt <= '0;
        end
        else if (bclk_rise)
        begin
          div_cnt <= (div_cnt == div_max) ? '0 : div_cnt + 3'h1;
        end
      end

      // a fresh gap after abort uses the settings just written; any partial gap is dropped
      always_ff @(posedge clk_sys)
      begin
        if (rst || kill || last_bit_end)
        begin
          gap_cnt <= '0;
        end
        else if (tick && !gap_done)
        begin
          gap_cnt <= gap_cnt + 8'h01;
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (rst || kill)
        begin
          eng_state <= sbfc_pkg::frame_gap_state;
        end
        else if (tick)
        begin
          unique case (eng_state)
            sbfc_pkg::frame_gap_state:
              if (gap_done && chan_on && tx_valid)
              begin
                eng_state <= sbfc_pkg::lead_delay_state;
              end
            sbfc_pkg::lead_delay_state: eng_state <= sbfc_pkg::lead_delay1_state;
            sbfc_pkg::lead_delay1_state: eng_state <= sbfc_pkg::lead_delay2_state;
            sbfc_pkg::lead_delay2_state: eng_state <= sbfc_pkg::bit_low_state;
            sbfc_pkg::bit_low_state: eng_state <= sbfc_pkg::bit_data_state;
            sbfc_pkg::bit_data_state: eng_state <= sbfc_pkg::bit_high_state;
            sbfc_pkg::bit_high_state:
              eng_state <= (bit_index == sbfc_pkg::BIT_INDEX_LAST) ? sbfc_pkg::rx_push_state
                           : sbfc_pkg::bit_low_state;
            sbfc_pkg::rx_push_state:
              if (rx_ready)
              begin
                eng_state <= sbfc_pkg::tx_pop_state;
              end
            sbfc_pkg::tx_pop_state: eng_state <= sbfc_pkg::frame_gap_state;
          endcase
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          bit_index <= '0;
          rx_shift <= '0;
        end
        else if (tick && (eng_state == sbfc_pkg::lead_delay2_state))
        begin
          bit_index <= message_size_sel ? sbfc_pkg::BIT_INDEX_SHORT : sbfc_pkg::BIT_INDEX_LONG;
          rx_shift <= '0;
        end
        else if (tick && (eng_state == sbfc_pkg::bit_data_state))
        begin
          rx_shift <= {rx_shift[18:0], return_line[c]};
        end
        else if (tick && (eng_state == sbfc_pkg::bit_high_state) && (bit_index != sbfc_pkg::BIT_INDEX_LAST))
        begin
          bit_index <= bit_index - 5'h01;
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (rst || kill)
        begin
          frame_q <= 1'b1;
          signal_q <= 1'b0;
        end
        else
        begin
          unique case (eng_state)
            sbfc_pkg::lead_delay_state, sbfc_pkg::lead_delay1_state, sbfc_pkg::lead_delay2_state:
            begin
              frame_q <= 1'b0;
              signal_q <= 1'b0;
            end
            sbfc_pkg::bit_low_state:
            begin
              frame_q <= 1'b0;
              signal_q <= 1'b0;
            end
            sbfc_pkg::bit_data_state:
            begin
              frame_q <= 1'b0;
              signal_q <= tx_bit;
            end
            sbfc_pkg::bit_high_state:
            begin
              frame_q <= 1'b0;
              signal_q <= 1'b1;
            end
            sbfc_pkg::frame_gap_state, sbfc_pkg::rx_push_state, sbfc_pkg::tx_pop_state:
            begin
              frame_q <= 1'b1;
              signal_q <= 1'b0;
            end
          endcase
        end
      end

      // each channel owns its fifos and engine; only the spi side is shared
      sbfc_fifo #(.WIDTH(sbfc_pkg::DATA_W), .DEPTH(sbfc_pkg::FIFO_DEPTH)) u_tx_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .flush(flush),
        .in_valid(tx_push),
        .in_data({tx_hi[c], byte_val}),
        .in_ready(tx_ready),
        .out_valid(tx_valid),
        .out_data(tx_word),
        .out_ready(tx_pop)
      );

      // a full receive fifo holds the engine in its push step
      sbfc_fifo #(.WIDTH(sbfc_pkg::RX_W), .DEPTH(sbfc_pkg::FIFO_DEPTH)) u_rx_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .flush(flush),
        .in_valid(rx_push),
        .in_data(rx_word),
        .in_ready(rx_ready),
        .out_valid(rx_valid),
        .out_data(rx_word_out),
        .out_ready(rx_pop)
      );
    end
  endgenerate
endmodule

`default_nettype wire

/* sbfc_top_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module sbfc_top_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // spi pins
  input wire logic spi_cs_n,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  // physical layer lines
  input wire logic [1:0] frame_line,
  input wire logic [1:0] signal_line
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // the two reset checks look inside reset, so they switch the default disable off
  AST_RST_LINES: assert property (disable iff (1'b0) rst |=> frame_line == 2'h3 && signal_line == 2'h0)
    else $error("lines not idle in reset");
  AST_RST_MISO: assert property (disable iff (1'b0) rst |=> !spi_miso)
    else $error("miso not cleared in reset");
  // fifos are empty after reset, so no frame can start this soon
  AST_QUIET_START: assert property ($fell(rst) |-> frame_line == 2'h3 [*8])
    else $error("frame started right after reset");
  AST_OE: assert property (spi_miso_oe == !spi_cs_n)
    else $error("miso enable does not follow select");
  AST_LEAD0: assert property ($fell(frame_line[0]) |-> !signal_line[0] [*3])
    else $error("channel 0 signal high in lead");
  AST_LEAD1: assert property ($fell(frame_line[1]) |-> !signal_line[1] [*3])
    else $error("channel 1 signal high in lead");
  AST_RISE0: assert property ($rose(signal_line[0]) |-> !frame_line[0])
    else $error("channel 0 signal pulse outside frame");
  AST_RISE1: assert property ($rose(signal_line[1]) |-> !frame_line[1])
    else $error("channel 1 signal pulse outside frame");
endmodule
bind sbfc_top sbfc_top_asserts u_chk (.clk_sys(clk_sys), .rst(rst), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
  .spi_miso_oe(spi_miso_oe), .frame_line(frame_line), .signal_line(signal_line));
`default_nettype wire

/* sbfc_spi_host.sv */
`timescale 1ns/10ps
`default_nettype none
module sbfc_spi_host (
  // clock
  input wire logic clk_sys,
  // spi master pins
  output logic spi_cs_n,
  output logic spi_sck,
  output logic spi_mosi,
  input wire logic spi_miso
);
  // clk_sys cycles per sck phase; the slave samples sck, so never below 2
  int half = 3;
  logic [7:0] wr [8];
  logic [7:0] rd [8];
  initial
  begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
  end
  task automatic xfer(input int k);
    for (int i = 7; i >= 0; i--)
    begin
      spi_mosi = wr[k][i];
      repeat (half) @(negedge clk_sys);
      spi_sck = 1'b1;
      rd[k][i] = spi_miso;
      repeat (half) @(negedge clk_sys);
      spi_sck = 1'b0;
    end
  endtask
  // wr[0] is the command, wr[1..n] the data bytes of one burst
  task automatic burst(input logic [7:0] cmd, input int n);
    repeat (half) @(negedge clk_sys);
    wr[0] = cmd;
    spi_cs_n = 1'b0;
    for (int k = 0; k <= n; k++)
      xfer(k);
    repeat (half) @(negedge clk_sys);
    spi_cs_n = 1'b1;
    // deselected line no longer carries the last bit
    spi_mosi = ~spi_mosi;
  endtask
endmodule
`default_nettype wire

/* testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic bit_clk_in = 1'b0;
  logic spi_cs_n, spi_sck, spi_mosi, spi_miso, spi_miso_oe;
  logic [1:0] frame_line, signal_line;
  logic [19:0] wire_bits;
  int lo_len, nbits, mismatches = 0, samples_checked = 0;
  always #2.5 clk_sys = ~clk_sys;
  initial #1 forever #10 bit_clk_in = ~bit_clk_in;
  // signal lines looped back, so received words must equal sent ones
  sbfc_top uut (.clk_sys(clk_sys), .rst(rst), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .bit_clk_in(bit_clk_in), .frame_line(frame_line),
    .signal_line(signal_line), .return_line(signal_line));
  sbfc_spi_host host (.clk_sys(clk_sys), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso));
  // a one stays low one tick (4 clk), a zero two; the lead adds 12 clk
  always @(negedge clk_sys)
  begin
    if (frame_line[0])
      lo_len = 0;
    else if (signal_line[0])
    begin
      if (lo_len > 0)
      begin
        wire_bits = {wire_bits[18:0], (lo_len % 12) < 6};
        nbits++;
      end
      lo_len = 0;
    end
    else
      lo_len++;
  end
  task automatic end_of_test;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: reg %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_wire(input logic [19:0] got, input logic [19:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: wire %h want %h", $time, got, exp);
    end
  endtask
  task automatic wait_bits(input int want);
    for (int n = 0; n < 3000 && nbits < want; n++)
      @(negedge clk_sys);
    repeat (40) @(negedge clk_sys);
  endtask
  task automatic t_reset;
    host.burst(8'h05, 3);
    for (int i = 0; i < 4; i++)
      chk_reg(host.rd[i], 8'h00);
    chk_wire({18'h0, frame_line}, 20'h3);
  endtask
  task automatic t_frame;
    host.wr[1] = 8'h00;
    host.wr[2] = 8'hff;
    host.wr[3] = 8'ha5;
    host.wr[4] = 8'h3c;
    nbits = 0;
    host.burst(8'h86, 4);
    wait_bits(20);
    chk_wire(wire_bits, 20'ha53c0);
    chk_wire(20'(nbits), 20'h14);
    chk_wire({19'h0, frame_line[1]}, 20'h1);
    host.burst(8'h07, 3);
    chk_reg(host.rd[1], 8'h03);
    chk_reg(host.rd[2], 8'ha5);
    chk_reg(host.rd[3], 8'h3c);
    host.burst(8'h04, 1);
    chk_reg(host.rd[1], 8'h66);
  endtask
  task automatic t_abort;
    host.wr[1] = 8'h81;
    host.wr[2] = 8'h18;
    host.burst(8'h80, 2);
    repeat (60) @(negedge clk_sys);
    chk_wire({19'h0, frame_line[0]}, 20'h0);
    host.wr[1] = 8'h40;
    host.burst(8'h85, 1);
    chk_wire({16'h0, frame_line, signal_line}, 20'hc);
    host.burst(8'h04, 1);
    chk_reg(host.rd[1], 8'h66);
    host.wr[1] = 8'h00;
    host.wr[2] = 8'hc3;
    nbits = 0;
    host.burst(8'h80, 2);
    wait_bits(12);
    chk_wire({8'h0, wire_bits[11:0]}, 20'hc30);
    chk_wire(20'(nbits), 20'h0c);
  endtask
  task automatic t_fill;
    // slowest divider and longest gap keep the engine off the fifo while it fills
    host.half = 5;
    host.wr[1] = 8'h0f;
    host.burst(8'h85, 1);
    for (int i = 0; i < 5; i++)
    begin
      host.wr[1] = 8'(i);
      host.wr[2] = 8'(i);
      host.burst(8'h80, 2);
    end
    host.burst(8'h04, 1);
    chk_reg(host.rd[1], 8'h60);
    chk_wire({19'h0, frame_line[0]}, 20'h1);
    host.wr[1] = 8'h02;
    host.burst(8'h87, 1);
    host.burst(8'h04, 1);
    chk_reg(host.rd[1], 8'h66);
    chk_wire({18'h0, frame_line}, 20'h3);
  endtask
  initial
  begin
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    t_reset;
    t_frame;
    t_abort;
    t_fill;
    end_of_test;
  end
  initial
  begin
    repeat (20000) @(negedge clk_sys);
    mismatches++;
    end_of_test;
  end
endmodule
`default_nettype wire
